// [ddr_burst_sram_port.sv]
// Two-word burst DDR static memory port, device side.
// Assumes k_clk and k_n_clk are complementary link clocks from the
// controller, and that clk_sys feeds an optional preload stream.
// Behaviour
// - Addresses accepted only on alternate K edges
// - Write words captured on K# and K rise
// - Read words launched on K# and K rise
// - Each address holds two fixed-width words
// - First read word 2.5 cycles after address
// - Valid flag marks read data on pins
// - Shared data pins, echo clocks track data
// - All link inputs pass input registers first
// - Only rising edges of both link clocks
// - Writes finish internally, no further controller timing
`timescale 1ns/1ns
module ddr_burst_sram_port #(
  parameter int WORD_W = sram_port_pkg::WORD_W_DEF,
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
  parameter int SEL_W = sram_port_pkg::SEL_W_DEF,
  parameter int FIFO_DEPTH = sram_port_pkg::LOAD_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load_valid,
  output logic load_ready,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [sram_port_pkg::BURST_WORDS*WORD_W-1:0] load_data,
  input wire logic k_clk,
  input wire logic k_n_clk,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic [WORD_W-1:0] dq_i,
  input wire logic [SEL_W-1:0] byte_write_select_n,
  output logic [WORD_W-1:0] q_on_k,
  output logic q_on_k_oe,
  output logic [WORD_W-1:0] q_on_kn,
  output logic q_on_kn_oe,
  output logic echo_clock_out,
  output logic echo_clock_out_n,
  output logic read_valid_flag
);
  import sram_port_pkg::*;
  localparam int REC_W = ADDR_W + BURST_WORDS*WORD_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ==================================================
  // Reset and enable brought into the link domain
  logic krst_n_meta_q;      // Reset sync, first stage
  logic krst_n_q;           // Reset sync, usable
  logic ce_meta_q;          // Enable sync, first stage
  logic ce_k_q;             // Enable sync, usable
  logic run_k;              // Link logic may advance

  // Two-flop synchronisers for reset release and clock enable
  always_ff @(posedge k_clk)
  begin
    krst_n_meta_q <= rst_n;
    krst_n_q <= krst_n_meta_q;
    ce_meta_q <= ce;
    ce_k_q <= ce_meta_q;
  end

  assign run_k = krst_n_q && ce_k_q;

  // ==================================================
  // Preload stream from the system clock
  logic pre_valid;                // Preload record waiting
  logic pre_ready;                // Array free for preload
  logic [REC_W-1:0] pre_rec;      // Preload record
  logic wr_s1_q;                  // Write burst commits next K edge

  // Preload only fills cycles that carry no link write
  assign pre_ready = run_k && !wr_s1_q;

  load_fifo #(
    .WIDTH(REC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_load_fifo (
    .wr_clk(clk_sys),
    .wr_rst_n(rst_n),
    .wr_ce(ce),
    .wr_valid(load_valid),
    .wr_ready(load_ready),
    .wr_data({load_addr, load_data}),
    .rd_clk(k_clk),
    .rd_rst_n(krst_n_q),
    .rd_ce(ce_k_q),
    .rd_valid(pre_valid),
    .rd_ready(pre_ready),
    .rd_data(pre_rec)
  );

  // ==================================================
  // Input registers on K
  logic [ADDR_W-1:0] addr_k_q;    // Registered address
  logic req_k_q;                  // Registered request, active high
  logic rd_k_q;                   // Registered read select
  logic [WORD_W-1:0] dq_k_q;      // Word captured on K
  logic [SEL_W-1:0] sel_k_q;      // Selects captured on K

  always_ff @(posedge k_clk)
  begin
    if (!krst_n_q)
    begin
      req_k_q <= RST_LEVEL_LOW;
      rd_k_q <= RST_LEVEL_LOW;
      addr_k_q <= '0;
      dq_k_q <= '0;
      sel_k_q <= '1;
    end
    else if (ce_k_q)
    begin
      req_k_q <= !load_strobe_n;
      rd_k_q <= read_not_write;
      addr_k_q <= addr_in;
      dq_k_q <= dq_i;
      sel_k_q <= byte_write_select_n;
    end
  end

  // ==================================================
  // Input registers on K#
  logic [WORD_W-1:0] dq_kn_q;     // Word captured on K#
  logic [SEL_W-1:0] sel_kn_q;     // Selects captured on K#

  always_ff @(posedge k_n_clk)
  begin
    if (!krst_n_q)
    begin
      dq_kn_q <= '0;
      sel_kn_q <= '1;
    end
    else if (ce_k_q)
    begin
      dq_kn_q <= dq_i;
      sel_kn_q <= byte_write_select_n;
    end
  end

  // ==================================================
  // Address acceptance on alternate edges
  addr_slot_e slot_q;             // Open or blocked for this edge
  logic accept;                   // Registered request taken now

  // Strobe must be low to start
  assign accept = req_k_q && (slot_q == slot_open);

  // Block the edge after each acceptance
  always_ff @(posedge k_clk)
  begin
    if (!krst_n_q)
    begin
      slot_q <= slot_open;
    end
    else if (ce_k_q)
    begin
      case (slot_q)
        slot_open:
        begin
          // Taken request blocks the following edge
          slot_q <= accept ? slot_blocked : slot_open;
        end
        slot_blocked:
        begin
          // Requests seen here are ignored
          slot_q <= slot_open;
        end
        default:
        begin
          slot_q <= slot_open;
        end
      endcase
    end
  end

  // ==================================================
  // Write path
  logic [ADDR_W-1:0] waddr_q;     // Address of burst being written
  logic [WORD_W-1:0] w0_q;        // First word held for commit
  logic [SEL_W-1:0] wsel0_q;      // Selects of first word

  // Collect the write burst: address, then first word from K#
  always_ff @(posedge k_clk)
  begin
    if (!krst_n_q)
    begin
      wr_s1_q <= RST_LEVEL_LOW;
      waddr_q <= '0;
      w0_q <= '0;
      wsel0_q <= '1;
    end
    else if (ce_k_q)
    begin
      wr_s1_q <= accept && !rd_k_q;
      if (accept && !rd_k_q)
      begin
        waddr_q <= addr_k_q;
        w0_q <= dq_kn_q;
        wsel0_q <= sel_kn_q;
      end
    end
  end

  // ==================================================
  // Storage array, two words per address
  logic [BURST_WORDS*WORD_W-1:0] mem [DEPTH];   // Burst array
  logic [ADDR_W-1:0] mem_addr;                  // Address written this edge
  logic [BURST_WORDS*WORD_W-1:0] mem_old;       // Current content there
  logic [WORD_W-1:0] merge0;                    // First word after selects
  logic [WORD_W-1:0] merge1;                    // Second word after selects
  logic mem_we;                                 // Write this edge

  // Link write wins the array; preload takes idle edges
  assign mem_addr = wr_s1_q ? waddr_q : pre_rec[REC_W-1 -: ADDR_W];
  assign mem_old = mem[mem_addr];
  assign mem_we = run_k && (wr_s1_q || pre_valid);

  lane_merge #(
    .WORD_W(WORD_W),
    .SEL_W(SEL_W)
  ) u_merge0 (
    .old_word(mem_old[WORD_W-1:0]),
    .new_word(w0_q),
    .sel_n(wsel0_q),
    .merged(merge0)
  );

  lane_merge #(
    .WORD_W(WORD_W),
    .SEL_W(SEL_W)
  ) u_merge1 (
    .old_word(mem_old[BURST_WORDS*WORD_W-1:WORD_W]),
    .new_word(dq_k_q),
    .sel_n(sel_k_q),
    .merged(merge1)
  );

  always_ff @(posedge k_clk)
  begin
    if (mem_we)
    begin
      if (wr_s1_q)
      begin
        mem[mem_addr] <= {merge1, merge0};
      end
      else
      begin
        // Preload writes the full burst
        mem[mem_addr] <= pre_rec[BURST_WORDS*WORD_W-1:0];
      end
    end
  end

  // ==================================================
  // Read pipeline on K
  logic rd_s1_q;                  // Burst fetched from array
  logic rd_s2_q;                  // Burst due on the pins
  logic [WORD_W-1:0] r0_q;        // First read word
  logic [WORD_W-1:0] r1_q;        // Second read word

  // Fetch one edge after capture, launch a cycle and a half later
  always_ff @(posedge k_clk)
  begin
    if (!krst_n_q)
    begin
      rd_s1_q <= RST_LEVEL_LOW;
      rd_s2_q <= RST_LEVEL_LOW;
      r0_q <= '0;
      r1_q <= '0;
    end
    else if (ce_k_q)
    begin
      rd_s1_q <= accept && rd_k_q;
      rd_s2_q <= rd_s1_q;
      if (accept && rd_k_q)
      begin
        {r1_q, r0_q} <= mem[addr_k_q];
      end
    end
  end

  // ==================================================
  // Output registers on K#: first word, valid flag, echo
  // First word launched on K#
  // Echo toggles with each K# launch edge
  always_ff @(posedge k_n_clk)
  begin
    if (!krst_n_q)
    begin
      q_on_kn <= '0;
      q_on_kn_oe <= RST_LEVEL_LOW;
      read_valid_flag <= RST_LEVEL_LOW;
      echo_clock_out_n <= RST_LEVEL_LOW;
    end
    else if (ce_k_q)
    begin
      q_on_kn_oe <= rd_s2_q;
      read_valid_flag <= rd_s2_q;
      echo_clock_out_n <= !echo_clock_out_n;
      if (rd_s2_q)
      begin
        q_on_kn <= r0_q;
      end
    end
  end

  // ==================================================
  // Output registers on K: second word and echo
  // Second word launched on K
  // Echo toggles with each K launch edge
  always_ff @(posedge k_clk)
  begin
    if (!krst_n_q)
    begin
      q_on_k <= '0;
      q_on_k_oe <= RST_LEVEL_LOW;
      echo_clock_out <= RST_LEVEL_LOW;
    end
    else if (ce_k_q)
    begin
      q_on_k_oe <= rd_s2_q;
      echo_clock_out <= !echo_clock_out;
      if (rd_s2_q)
      begin
        q_on_k <= r1_q;
      end
    end
  end
endmodule : ddr_burst_sram_port

// [sram_port_pkg.sv]
// Shared constants for the two-word burst memory port.
// Assumes both clock domains import it; holds no logic.
package sram_port_pkg;
  // ==================================================
  // Geometry defaults
  localparam int WORD_W_DEF = 36;   // Bits per data word
  localparam int ADDR_W_DEF = 19;   // Address bits, one burst per address
  localparam int SEL_W_DEF = 4;     // Write select lanes per word
  localparam int BURST_WORDS = 2;   // Words that share one address
  localparam int LOAD_FIFO_DEPTH = 16; // Preload FIFO entries
  // ==================================================
  // Read latency, in half cycles of the link clock
  localparam int READ_LATENCY_HALF = 5;
  // ==================================================
  // Reset values
  localparam logic RST_LEVEL_LOW = 1'b0;  // Cleared control level
  localparam logic SYNC_SET = 1'b1;       // Level once released
  // Address slot state: blocked right after an accepted address
  typedef enum logic {slot_open, slot_blocked} addr_slot_e;
endpackage : sram_port_pkg

// [load_fifo.sv]
// Dual-clock FIFO carrying preload records from the system clock
// into the link clock. Assumes both resets are already synchronous
// to their own clocks. Pointers cross in gray code.
`timescale 1ns/1ns
module load_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_ce,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  input wire logic rd_ce,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  import sram_port_pkg::*;
  localparam int PW = $clog2(DEPTH);
  // ==================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];        // Entries
  logic [PW:0] wbin_q;                   // Write pointer, binary
  logic [PW:0] wgray_q;                  // Write pointer, gray
  logic [PW:0] rbin_q;                   // Read pointer, binary
  logic [PW:0] rgray_q;                  // Read pointer, gray
  logic [PW:0] rgray_meta_q;             // Read pointer into write side, stage 1
  logic [PW:0] rgray_sync_q;             // Read pointer into write side, stage 2
  logic [PW:0] wgray_meta_q;             // Write pointer into read side, stage 1
  logic [PW:0] wgray_sync_q;             // Write pointer into read side, stage 2
  logic [PW:0] wbin_d;
  logic [PW:0] wgray_d;
  logic [PW:0] rbin_d;
  logic [PW:0] rgray_d;
  logic push;
  logic pop;

  assign push = wr_valid && wr_ready && wr_ce;
  assign pop = rd_valid && rd_ready && rd_ce;
  assign wbin_d = wbin_q + (PW+1)'(push);
  assign wgray_d = wbin_d ^ (wbin_d >> 1);
  assign rbin_d = rbin_q + (PW+1)'(pop);
  assign rgray_d = rbin_d ^ (rbin_d >> 1);
  assign rd_data = mem[rbin_q[PW-1:0]];

  // ==================================================
  // Write side: store, advance, registered ready
  always_ff @(posedge wr_clk)
  begin
    if (push)
    begin
      mem[wbin_q[PW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk)
  begin
    if (!wr_rst_n)
    begin
      wbin_q <= '0;
      wgray_q <= '0;
      rgray_meta_q <= '0;
      rgray_sync_q <= '0;
      wr_ready <= RST_LEVEL_LOW;
    end
    else if (wr_ce)
    begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      rgray_meta_q <= rgray_q;
      rgray_sync_q <= rgray_meta_q;
      // Full when next write pointer laps the read pointer
      wr_ready <= wgray_d != {~rgray_sync_q[PW:PW-1], rgray_sync_q[PW-2:0]};
    end
  end

  // ==================================================
  // Read side: advance, registered valid
  always_ff @(posedge rd_clk)
  begin
    if (!rd_rst_n)
    begin
      rbin_q <= '0;
      rgray_q <= '0;
      wgray_meta_q <= '0;
      wgray_sync_q <= '0;
      rd_valid <= RST_LEVEL_LOW;
    end
    else if (rd_ce)
    begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      wgray_meta_q <= wgray_q;
      wgray_sync_q <= wgray_meta_q;
      // Empty when next read pointer meets the write pointer
      rd_valid <= rgray_d != wgray_sync_q;
    end
  end
endmodule : load_fifo

// [lane_merge.sv]
// Merges one data word into a stored word under active-low lane
// selects. Purely combinational; one generate loop over lanes.
`timescale 1ns/1ns
module lane_merge #(
  parameter int WORD_W = 36,
  parameter int SEL_W = 4
) (
  input wire logic [WORD_W-1:0] old_word,
  input wire logic [WORD_W-1:0] new_word,
  input wire logic [SEL_W-1:0] sel_n,
  output logic [WORD_W-1:0] merged
);
  import sram_port_pkg::*;
  localparam int LANE_W = WORD_W / SEL_W;
  // ==================================================
  // Each lane takes new data only when its select is low
  for (genvar g = 0; g < SEL_W; g++)
  begin : g_lane
    assign merged[g*LANE_W +: LANE_W] = sel_n[g] ? old_word[g*LANE_W +: LANE_W]
                                                 : new_word[g*LANE_W +: LANE_W];
  end
endmodule : lane_merge

// [ddr_burst_sram_port_chk.sv]
// Checker for the burst memory port: link-side read timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module ddr_burst_sram_port_chk #(
  parameter int WORD_W = 36
) (
  input wire logic rst_n,
  input wire logic k_clk,
  input wire logic k_n_clk,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic [WORD_W-1:0] q_on_k,
  input wire logic q_on_k_oe,
  input wire logic q_on_kn_oe,
  input wire logic echo_clock_out,
  input wire logic echo_clock_out_n,
  input wire logic read_valid_flag
);
  // ==================================================
  // Helper state
  logic take_q; // Request taken at last K rise
  logic rd_q; // That request was a read
  logic [2:0] run_q; // K rises since reset, saturating
  // Mirror request acceptance at each K rise
  always_ff @(posedge k_clk)
  begin
    if (!rst_n)
    begin
      take_q <= 1'b0;
      rd_q <= 1'b0;
      run_q <= 3'h0;
    end
    else
    begin
      take_q <= !load_strobe_n && !take_q;
      rd_q <= read_not_write;
      if (run_q != 3'h7)
        run_q <= run_q + 3'h1;
    end
  end
  // ==================================================
  // Properties
  property p_read_valid;
    @(posedge k_clk) disable iff (!rst_n) take_q && rd_q |-> ##2 read_valid_flag ##1 q_on_k_oe;
  endproperty
  a_read_valid: assert property (p_read_valid)
    else $error("read answer late or missing");
  property p_valid_cause;
    @(posedge k_clk) disable iff (!rst_n) $rose(read_valid_flag) |-> $past(take_q && rd_q, 2);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("valid flag without a read");
  property p_write_quiet;
    @(posedge k_clk) disable iff (!rst_n) take_q && !rd_q |-> ##2 !q_on_kn_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("pins driven after a write");
  property p_refused;
    @(posedge k_clk) disable iff (!rst_n)
      take_q && !rd_q && !load_strobe_n && read_not_write |-> ##3 !read_valid_flag;
  endproperty
  a_refused: assert property (p_refused)
    else $error("request on adjacent edge accepted");
  property p_valid_oe;
    @(posedge k_clk) disable iff (!rst_n) read_valid_flag == q_on_kn_oe;
  endproperty
  a_valid_oe: assert property (p_valid_oe)
    else $error("valid flag and first word enable differ");
  property p_oe_pair;
    @(posedge k_clk) disable iff (!rst_n) $rose(q_on_kn_oe) |=> q_on_k_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("second word not launched on K");
  property p_echo;
    @(posedge k_clk) disable iff (!rst_n) run_q == 3'h7 |-> echo_clock_out != $past(echo_clock_out);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo clock did not toggle");
  property p_echo_n;
    @(posedge k_n_clk) disable iff (!rst_n)
      run_q == 3'h7 |-> echo_clock_out_n != $past(echo_clock_out_n);
  endproperty
  a_echo_n: assert property (p_echo_n)
    else $error("complementary echo did not toggle");
  property p_q_hold;
    @(posedge k_clk) disable iff (!rst_n)
      run_q == 3'h7 && !$past(take_q && rd_q, 3) |-> $stable(q_on_k);
  endproperty
  a_q_hold: assert property (p_q_hold)
    else $error("second word changed without a read");
endmodule : ddr_burst_sram_port_chk

bind ddr_burst_sram_port ddr_burst_sram_port_chk #(.WORD_W(WORD_W)) i_ddr_burst_sram_port_chk (
  .rst_n(rst_n), .k_clk(k_clk), .k_n_clk(k_n_clk), .load_strobe_n(load_strobe_n),
  .read_not_write(read_not_write), .q_on_k(q_on_k), .q_on_k_oe(q_on_k_oe),
  .q_on_kn_oe(q_on_kn_oe), .echo_clock_out(echo_clock_out),
  .echo_clock_out_n(echo_clock_out_n), .read_valid_flag(read_valid_flag));

// [mem_ctrl_model.sv]
// Memory controller model: makes K and K#, issues bursts.
// Assumes the testbench calls its tasks; K stops low when k_run falls.
`timescale 1ns/1ns
module mem_ctrl_model #(
  parameter int ADDR_W = 6,
  parameter int WORD_W = 36,
  parameter int SEL_W = 4
) (
  input wire logic k_run,
  output logic k_clk,
  output logic k_n_clk,
  output logic [ADDR_W-1:0] addr_in,
  output logic load_strobe_n,
  output logic read_not_write,
  output logic [WORD_W-1:0] dq_i,
  output logic [SEL_W-1:0] byte_write_select_n,
  input wire logic [WORD_W-1:0] q_on_k,
  input wire logic [WORD_W-1:0] q_on_kn,
  input wire logic q_on_k_oe,
  input wire logic q_on_kn_oe,
  input wire logic read_valid_flag
);
  assign k_n_clk = ~k_clk; // Complement clock
  // ==================================================
  // Idle pins and link clock, 12 ns period
  initial
  begin
    k_clk = 1'b0;
    addr_in = '0;
    load_strobe_n = 1'b1;
    read_not_write = 1'b0;
    dq_i = '0;
    byte_write_select_n = '1;
    forever
    begin
      #6;
      if (k_run || k_clk)
        k_clk = ~k_clk;
    end
  end
  task automatic request(input logic rd, input logic [ADDR_W-1:0] a);
    @(posedge k_clk);
    load_strobe_n <= 1'b0;
    read_not_write <= rd;
    addr_in <= a;
  endtask : request
  // words with selects; hold makes a too-close read
  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [2*WORD_W-1:0] d,
    input logic [2*SEL_W-1:0] s, input logic hold, output logic quiet);
    request(1'b0, a);
    @(posedge k_clk);
    load_strobe_n <= !hold;
    read_not_write <= hold;
    addr_in <= ~a;
    dq_i <= d[WORD_W-1:0];
    byte_write_select_n <= s[SEL_W-1:0];
    @(posedge k_n_clk);
    dq_i <= d[2*WORD_W-1:WORD_W];
    byte_write_select_n <= s[2*SEL_W-1:SEL_W];
    @(posedge k_clk);
    load_strobe_n <= 1'b1;
    dq_i <= ~d[2*WORD_W-1:WORD_W];
    byte_write_select_n <= ~s[2*SEL_W-1:SEL_W];
    quiet = 1'b1;
    repeat (4)
    begin
      @(posedge k_n_clk);
      #1 quiet = quiet && (read_valid_flag === 1'b0);
    end
  endtask : write_burst
  // Read burst: first word at K# n+2.5, second at K n+3
  task automatic read_burst(input logic [ADDR_W-1:0] a, output logic [2*WORD_W-1:0] d,
    output logic ok);
    request(1'b1, a);
    @(posedge k_clk);
    load_strobe_n <= 1'b1;
    addr_in <= ~a;
    repeat (3) @(posedge k_n_clk);
    #1 d[WORD_W-1:0] = q_on_kn;
    ok = read_valid_flag && q_on_kn_oe;
    @(posedge k_clk);
    #1 d[2*WORD_W-1:WORD_W] = q_on_k;
    ok = ok && q_on_k_oe;
  endtask : read_burst
endmodule : mem_ctrl_model

// [ddr_two_word_burst_sram_port_tb.sv]
// Testbench for the burst memory port with a controller model.
// Assumes 100 MHz system clock; the model makes the 12 ns link clock.
`timescale 1ns/1ns
module ddr_two_word_burst_sram_port_tb;
  import sram_port_pkg::*;
  localparam int AW = 6;
  localparam int WW = WORD_W_DEF;
  localparam int SW = SEL_W_DEF;
  localparam int DW = 2 * WW;
  logic clk_sys, rst_n, ce, load_valid, load_ready, k_run, k_clk, k_n_clk;
  logic load_strobe_n, read_not_write, q_on_k_oe, q_on_kn_oe, read_valid_flag;
  logic echo_clock_out, echo_clock_out_n;
  logic [AW-1:0] load_addr, addr_in;
  logic [DW-1:0] load_data;
  logic [WW-1:0] dq_i, q_on_k, q_on_kn;
  logic [SW-1:0] byte_write_select_n;
  int mismatches = 0;
  int compares = 0;
  // ==================================================
  // Design and far side
  ddr_burst_sram_port #(.ADDR_W(AW)) i_ddr_burst_sram_port (.clk_sys(clk_sys),
    .rst_n(rst_n), .ce(ce), .load_valid(load_valid), .load_ready(load_ready),
    .load_addr(load_addr), .load_data(load_data), .k_clk(k_clk), .k_n_clk(k_n_clk),
    .addr_in(addr_in), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
    .dq_i(dq_i), .byte_write_select_n(byte_write_select_n), .q_on_k(q_on_k),
    .q_on_k_oe(q_on_k_oe), .q_on_kn(q_on_kn), .q_on_kn_oe(q_on_kn_oe),
    .echo_clock_out(echo_clock_out), .echo_clock_out_n(echo_clock_out_n),
    .read_valid_flag(read_valid_flag));
  mem_ctrl_model #(.ADDR_W(AW), .WORD_W(WW), .SEL_W(SW)) i_mem_ctrl_model (.k_run(k_run),
    .k_clk(k_clk), .k_n_clk(k_n_clk), .addr_in(addr_in), .load_strobe_n(load_strobe_n),
    .read_not_write(read_not_write), .dq_i(dq_i), .byte_write_select_n(byte_write_select_n),
    .q_on_k(q_on_k), .q_on_kn(q_on_kn), .q_on_k_oe(q_on_k_oe), .q_on_kn_oe(q_on_kn_oe),
    .read_valid_flag(read_valid_flag));
  // ==================================================
  // Helpers
  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Lane merge of one word under active-low selects
  function automatic logic [WW-1:0] mrg(input logic [WW-1:0] o, input logic [WW-1:0] n,
    input logic [SW-1:0] s);
    for (int i = 0; i < SW; i++)
      if (!s[i])
        o[i*(WW/SW) +: (WW/SW)] = n[i*(WW/SW) +: (WW/SW)];
    return o;
  endfunction : mrg
  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // ==================================================
  // Scenarios
  task automatic t_write_read();
    logic [DW-1:0] d;
    logic ok, q;
    i_mem_ctrl_model.write_burst(6'h05, {36'h123456789, 36'hfedcba987}, 8'h00, 1'b0, q);
    i_mem_ctrl_model.write_burst(6'h06, {36'h0aaaaaaaa, 36'h555555555}, 8'h00, 1'b0, q);
    i_mem_ctrl_model.read_burst(6'h05, d, ok);
    check(d, {36'h123456789, 36'hfedcba987});
    check({71'h0, ok}, 72'h1);
    i_mem_ctrl_model.read_burst(6'h06, d, ok);
    check(d, {36'h0aaaaaaaa, 36'h555555555});
  endtask : t_write_read
  task automatic t_lanes();
    logic [DW-1:0] d;
    logic ok, q;
    i_mem_ctrl_model.write_burst(6'h05, {36'h111111111, 36'h222222222}, 8'ha5, 1'b0, q);
    i_mem_ctrl_model.read_burst(6'h05, d, ok);
    check(d, {mrg(36'h123456789, 36'h111111111, 4'ha),
      mrg(36'hfedcba987, 36'h222222222, 4'h5)});
  endtask : t_lanes
  task automatic t_refused();
    logic [DW-1:0] d;
    logic ok, q;
    i_mem_ctrl_model.write_burst(6'h07, {36'h0c0c0c0c0, 36'h303030303}, 8'h00, 1'b1, q);
    check({71'h0, q}, 72'h1);
    i_mem_ctrl_model.read_burst(6'h07, d, ok);
    check(d, {36'h0c0c0c0c0, 36'h303030303});
  endtask : t_refused
  task automatic t_preload();
    logic [DW-1:0] d;
    logic ok, acc;
    int n;
    k_run <= 1'b0;
    repeat (20) @(posedge clk_sys);
    n = 0;
    load_valid <= 1'b1;
    load_addr <= 6'h00;
    load_data <= {36'h100, 36'h0};
    repeat (40)
    begin
      @(negedge clk_sys);
      acc = load_ready;
      @(posedge clk_sys);
      if (acc === 1'b1)
      begin
        n = n + 1;
        load_addr <= AW'(n);
        load_data <= {WW'(n) + 36'h100, WW'(n)};
      end
    end
    load_valid <= 1'b0;
    check(DW'(n), DW'(LOAD_FIFO_DEPTH));
    k_run <= 1'b1;
    repeat (150) @(posedge clk_sys);
    check({71'h0, load_ready}, 72'h1);
    i_mem_ctrl_model.read_burst(6'h0f, d, ok);
    check(d, {36'h10f, 36'h00f});
  endtask : t_preload
  // ==================================================
  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    k_run = 1'b1;
    load_valid = 1'b0;
    load_addr = 6'h00;
    load_data = 72'h0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    t_write_read();
    t_lanes();
    t_refused();
    t_preload();
    complete_run();
  end
  // Watchdog against a hang
  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule : ddr_two_word_burst_sram_port_tb
